// ### hdl/mcc_pkg.sv
// Constants, register map and state codes of the main clock controller
//==================================================================
// What this block does
// - Clock-out select bit 7 drives core clock on pin; cleared leaves pin free
// - Clock-out is suspended during active halt even when selected
// - Slow divider bits 6:5 give oscillator clock divided by 2, 4, 8, 16
// - Slow divider acts only in slow mode; normal mode is undivided
// - Slow-mode bit 4 low gives undivided clock, high applies slow divider
// - Time base bits 3:2 give periods of 16000, 32000, 80000, 200000 cycles
// - A new time base applies only after the running period ends
// - Timeout flag bit 0 sets at period end; a status read clears it unless a period ends in the same cycle
// - Interrupt enable bit 1 passes each timeout as interrupt request
// - With interrupt enabled, halt enters active halt; timeout wakes device
// - Tone bits 1:0 select off, about 2 kHz, 1 kHz, 500 Hz, half duty
// - Tone keeps running in active halt
// - Full halt freezes time base and registers until a wake interrupt
`default_nettype none
package mcc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] MCC_CSR_IDX      = 8'h2C;
  localparam logic [7:0] MCC_TONE_IDX     = 8'h2D;
  localparam logic [7:0] MCC_CSR_ADDR     = 8'hB0;
  localparam logic [7:0] MCC_TONE_ADDR    = 8'hB4;
  localparam logic [7:0] MCC_CSR_RESET    = 8'h00;
  localparam logic [7:0] MCC_TONE_RESET   = 8'h00;

  // Field positions of the control/status and tone registers
  localparam int MCC_CLKOUT_BIT  = 7;
  localparam int MCC_DIV_HI      = 6;
  localparam int MCC_DIV_LO      = 5;
  localparam int MCC_SLOW_BIT    = 4;
  localparam int MCC_TB_HI       = 3;
  localparam int MCC_TB_LO       = 2;
  localparam int MCC_IRQEN_BIT   = 1;
  localparam int MCC_FLAG_BIT    = 0;
  localparam int MCC_TONE_HI     = 1;
  localparam int MCC_TONE_LO     = 0;

  // Time base periods in oscillator cycles
  localparam int MCC_TB_PERIOD0  = 16000;
  localparam int MCC_TB_PERIOD1  = 32000;
  localparam int MCC_TB_PERIOD2  = 80000;
  localparam int MCC_TB_PERIOD3  = 200000;
  localparam int MCC_TB_WIDTH    = 18;

  // Tone half periods in oscillator cycles, for an 8 MHz oscillator
  localparam int MCC_TONE_HALF1  = 2000;
  localparam int MCC_TONE_HALF2  = 4000;
  localparam int MCC_TONE_HALF3  = 8000;
  localparam int MCC_TONE_WIDTH  = 13;

  localparam int MCC_PRE_WIDTH   = 4;

  typedef enum logic [1:0] {
    MCC_RUN   = 2'b00,
    MCC_AHALT = 2'b01,
    MCC_FHALT = 2'b10
  } mcc_state_t;
endpackage
`default_nettype wire

// ### hdl/mcc_cnt.sv
// Free-running wrap counter used for the prescaler, time base and tone
`timescale 1ns/1ps
`default_nettype none
module mcc_cnt #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] top,
  output logic      [WIDTH-1:0] count,
  output logic                  wrap
);
  logic [WIDTH-1:0] count_nxt;

  assign wrap      = run && (count >= top);
  assign count_nxt = clear ? '0 : wrap ? '0 : run ? count + 1'b1 : count;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else
      count <= count_nxt;
  end
endmodule
`default_nettype wire

// ### hdl/mcc_top.sv
// Main clock controller: prescaler, clock-out, time base and tone, APB slave
`timescale 1ns/1ps
`default_nettype none
module mcc_top
  import mcc_pkg::*;
#(
  parameter int TB_PERIOD0 = MCC_TB_PERIOD0,
  parameter int TB_PERIOD1 = MCC_TB_PERIOD1,
  parameter int TB_PERIOD2 = MCC_TB_PERIOD2,
  parameter int TB_PERIOD3 = MCC_TB_PERIOD3,
  parameter int TONE_HALF1 = MCC_TONE_HALF1,
  parameter int TONE_HALF2 = MCC_TONE_HALF2,
  parameter int TONE_HALF3 = MCC_TONE_HALF3
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        halt_cmd,
  input  wire logic        halt_wake,
  output logic             core_clk_en,
  output logic             clock_out_pin,
  output logic             clock_out_oe,
  output logic             tone_pin,
  output logic             tone_oe,
  output logic             tick_irq,
  output logic             active_halt,
  output logic             full_halt
);
  //==================================================================
  // Registers and state
  mcc_state_t                state_r;
  mcc_state_t                state_nxt;
  logic                      clock_out_select_r;
  logic [1:0]                slow_divider_select_r;
  logic                      slow_mode_select_r;
  logic [1:0]                time_base_select_r;
  logic [1:0]                tb_cur_r;
  logic                      tick_irq_enable_r;
  logic                      tick_timeout_flag_r;
  logic                      flag_nxt;
  logic [1:0]                tone_select_r;

  //==================================================================
  // APB decode
  wire                       setup_ph   = psel && !penable;
  wire                       access_ok  = psel && penable && pready;
  wire                       hit_csr    = (paddr == MCC_CSR_ADDR);
  wire                       hit_tone   = (paddr == MCC_TONE_ADDR);
  wire                       hit_any    = hit_csr || hit_tone;
  wire                       running    = (state_r == MCC_RUN);
  // Halt modes freeze the registers; the core issues no access there
  wire                       wr_en      = access_ok && pwrite && running;
  wire                       wr_csr     = wr_en && hit_csr;
  wire                       wr_tone    = wr_en && hit_tone;
  wire                       rd_csr     = access_ok && !pwrite && hit_csr && running;

  wire [7:0]                 csr_view   = {clock_out_select_r, slow_divider_select_r,
                                           slow_mode_select_r, time_base_select_r,
                                           tick_irq_enable_r, tick_timeout_flag_r};
  wire [7:0]                 tone_view  = {6'h00, tone_select_r};
  wire [7:0]                 rd_byte    = hit_csr ? csr_view : hit_tone ? tone_view : 8'h00;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup_ph;
      pslverr <= setup_ph && !hit_any;
      prdata  <= setup_ph ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  //==================================================================
  // Register file
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clock_out_select_r    <= MCC_CSR_RESET[MCC_CLKOUT_BIT];
      slow_divider_select_r <= MCC_CSR_RESET[MCC_DIV_HI:MCC_DIV_LO];
      slow_mode_select_r    <= MCC_CSR_RESET[MCC_SLOW_BIT];
      time_base_select_r    <= MCC_CSR_RESET[MCC_TB_HI:MCC_TB_LO];
      tick_irq_enable_r     <= MCC_CSR_RESET[MCC_IRQEN_BIT];
      tone_select_r         <= MCC_TONE_RESET[MCC_TONE_HI:MCC_TONE_LO];
    end
    else
    begin
      if (wr_csr)
      begin
        clock_out_select_r    <= pwdata[MCC_CLKOUT_BIT];
        slow_divider_select_r <= pwdata[MCC_DIV_HI:MCC_DIV_LO];
        slow_mode_select_r    <= pwdata[MCC_SLOW_BIT];
        time_base_select_r    <= pwdata[MCC_TB_HI:MCC_TB_LO];
        tick_irq_enable_r     <= pwdata[MCC_IRQEN_BIT];
      end
      // Reserved tone bits are not stored and read back as zero
      if (wr_tone)
        tone_select_r <= pwdata[MCC_TONE_HI:MCC_TONE_LO];
    end
  end

  //==================================================================
  // Halt sequencing
  wire                       tb_wrap;
  wire                       tb_run     = (state_r != MCC_FHALT);
  wire                       wake_irq   = tb_wrap && tick_irq_enable_r;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      MCC_RUN:
        if (halt_cmd)
          state_nxt = tick_irq_enable_r ? MCC_AHALT : MCC_FHALT;
      MCC_AHALT:
        if (wake_irq || halt_wake)
          state_nxt = MCC_RUN;
      MCC_FHALT:
        if (halt_wake)
          state_nxt = MCC_RUN;
      default:
        state_nxt = MCC_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r     <= MCC_RUN;
      active_halt <= 1'b0;
      full_halt   <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      active_halt <= (state_nxt == MCC_AHALT);
      full_halt   <= (state_nxt == MCC_FHALT);
    end
  end

  //==================================================================
  // Time base
  logic [MCC_TB_WIDTH-1:0]   tb_top;
  logic [MCC_TB_WIDTH-1:0]   tb_count;

  always_comb
  begin
    case (tb_cur_r)
      2'b00:   tb_top = MCC_TB_WIDTH'(TB_PERIOD0 - 1);
      2'b01:   tb_top = MCC_TB_WIDTH'(TB_PERIOD1 - 1);
      2'b10:   tb_top = MCC_TB_WIDTH'(TB_PERIOD2 - 1);
      default: tb_top = MCC_TB_WIDTH'(TB_PERIOD3 - 1);
    endcase
  end

  mcc_cnt #(
    .WIDTH (MCC_TB_WIDTH)
  ) u_tb_cnt (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (1'b0),
    .run   (tb_run),
    .top   (tb_top),
    .count (tb_count),
    .wrap  (tb_wrap)
  );

  // Set beats the read clear so a timeout never vanishes unseen
  assign flag_nxt = tb_wrap ? 1'b1 : rd_csr ? 1'b0 : tick_timeout_flag_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tb_cur_r            <= 2'b00;
      tick_timeout_flag_r <= 1'b0;
      tick_irq            <= 1'b0;
    end
    else
    begin
      if (tb_wrap)
        tb_cur_r <= time_base_select_r;
      tick_timeout_flag_r <= flag_nxt;
      tick_irq            <= flag_nxt && (wr_csr ? pwdata[MCC_IRQEN_BIT]
                                                 : tick_irq_enable_r);
    end
  end

  //==================================================================
  // Core clock prescaler, expressed as a clock enable
  logic [MCC_PRE_WIDTH-1:0]  pre_top;
  logic [MCC_PRE_WIDTH-1:0]  pre_count;
  wire                       pre_wrap;

  always_comb
  begin
    case (slow_divider_select_r)
      2'b00:   pre_top = 4'h1;
      2'b01:   pre_top = 4'h3;
      2'b10:   pre_top = 4'h7;
      default: pre_top = 4'hF;
    endcase
  end

  mcc_cnt #(
    .WIDTH (MCC_PRE_WIDTH)
  ) u_pre_cnt (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (!slow_mode_select_r || !running),
    .run   (slow_mode_select_r && running),
    .top   (pre_top),
    .count (pre_count),
    .wrap  (pre_wrap)
  );

  // Core clock stops in both halt modes
  wire                       core_en_nxt = running && (!slow_mode_select_r || pre_wrap);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_clk_en   <= 1'b0;
      clock_out_pin <= 1'b0;
      clock_out_oe  <= 1'b0;
    end
    else
    begin
      core_clk_en   <= core_en_nxt;
      // Suspended in active halt to save power; enable stays with the bit
      clock_out_pin <= clock_out_select_r && core_en_nxt;
      clock_out_oe  <= clock_out_select_r;
    end
  end

  //==================================================================
  // Tone generator
  logic [MCC_TONE_WIDTH-1:0] tone_top;
  logic [MCC_TONE_WIDTH-1:0] tone_count;
  wire                       tone_wrap;
  wire                       tone_on  = (tone_select_r != 2'b00);
  // Runs in active halt; only full halt freezes it
  wire                       tone_run = tone_on && tb_run;

  always_comb
  begin
    case (tone_select_r)
      2'b01:   tone_top = MCC_TONE_WIDTH'(TONE_HALF1 - 1);
      2'b10:   tone_top = MCC_TONE_WIDTH'(TONE_HALF2 - 1);
      default: tone_top = MCC_TONE_WIDTH'(TONE_HALF3 - 1);
    endcase
  end

  mcc_cnt #(
    .WIDTH (MCC_TONE_WIDTH)
  ) u_tone_cnt (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (!tone_on),
    .run   (tone_run),
    .top   (tone_top),
    .count (tone_count),
    .wrap  (tone_wrap)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tone_pin <= 1'b0;
      tone_oe  <= 1'b0;
    end
    else
    begin
      tone_pin <= tone_on && (tone_wrap ? !tone_pin : tone_pin);
      tone_oe  <= tone_on;
    end
  end

  //==================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_flag_set_tb: assert property (tb_wrap |=> tick_timeout_flag_r)
    else $error("timeout flag not set at period end");
  a_flag_read_clr: assert property (rd_csr && !tb_wrap |=> !tick_timeout_flag_r)
    else $error("status read did not clear timeout flag");
  a_irq_gate_en: assert property (tick_irq == (tick_timeout_flag_r && tick_irq_enable_r))
    else $error("interrupt request does not follow flag and enable");
  a_tb_keep_period: assert property (!tb_wrap |=> $stable(tb_cur_r))
    else $error("time base changed inside a period");
  a_tb_period_len: assert property (tb_wrap && tb_cur_r == 2'b00 |->
    tb_count == MCC_TB_WIDTH'(TB_PERIOD0 - 1))
    else $error("shortest time base period wrong");
  a_clkout_ahalt: assert property (active_halt |-> ##1 !clock_out_pin)
    else $error("clock-out active in active halt");
  a_normal_full: assert property (running && !slow_mode_select_r |=> core_clk_en)
    else $error("core clock divided in normal mode");
  a_slow_gap: assert property (running && slow_mode_select_r && pre_count == 4'h0 |=> !core_clk_en)
    else $error("slow mode enable pulse too dense");
  a_halt_entry: assert property (running && halt_cmd |=> (active_halt == tick_irq_enable_r) && (full_halt != tick_irq_enable_r))
    else $error("wrong halt mode entered");
  a_fhalt_freeze: assert property (state_r == MCC_FHALT |=> $stable(tb_count) && $stable(csr_view))
    else $error("full halt did not freeze time base");
  a_tone_off_low: assert property (!tone_on |=> !tone_pin && !tone_oe)
    else $error("tone pin active while tone off");
  a_apb_ready: assert property (setup_ph |=> pready ##1 !pready)
    else $error("apb ready timing wrong");

  // Pin and time base checks: a stuck pin driver would slip past the register checks above
  a_clkout_oe_sel: assert property (clock_out_oe == $past(clock_out_select_r))
    else $error("clock-out enable does not follow select bit");
  a_clkout_copy: assert property (clock_out_select_r |=> clock_out_pin == core_clk_en)
    else $error("clock-out pin does not show core clock");
  a_tone_ahalt_run: assert property (active_halt && tone_wrap |=> tone_pin != $past(tone_pin))
    else $error("tone stopped in active halt");
  a_ahalt_tb_runs: assert property (active_halt |=> !$stable(tb_count))
    else $error("time base stopped in active halt");
  a_irq_off_quiet: assert property (!tick_irq_enable_r && !wr_csr |=> !tick_irq)
    else $error("interrupt request raised while disabled");

  c_timeout_read: cover property (tick_timeout_flag_r ##1 rd_csr);
  c_ahalt_wake: cover property (active_halt && wake_irq);
  c_tone_toggle: cover property (tone_oe && $rose(tone_pin));
  c_slow_div16: cover property (slow_mode_select_r && slow_divider_select_r == 2'b11 && pre_wrap);
  c_fhalt_wake: cover property (full_halt && halt_wake);
endmodule
`default_nettype wire

// ### test/mcc_ext.sv
// Listener model of the devices fed by the clock-out and tone pins
`timescale 1ns/1ps
`default_nettype none
module mcc_ext (
  input  wire logic        clk,
  input  wire logic        clr,
  input  wire logic        co_pin,
  input  wire logic        tn_pin,
  output logic      [15:0] co_cnt,
  output logic      [15:0] tn_edges,
  output logic      [15:0] tn_half
);
  logic        tn_q;
  logic [15:0] run;

  // ==================================================================
  // Pulse and edge counting
  // Listeners only: neither pin is ever driven back into the block
  always_ff @(posedge clk)
  begin
    tn_q <= tn_pin;
    if (clr)
    begin
      co_cnt   <= 16'h0;
      tn_edges <= 16'h0;
      run      <= 16'h1;
    end
    else
    begin
      co_cnt <= co_cnt + {15'h0, co_pin};
      if (tn_pin != tn_q)
      begin
        tn_edges <= tn_edges + 16'h1;
        tn_half  <= run;
        run      <= 16'h1;
      end
      else
        run <= run + 16'h1;
    end
  end
endmodule
`default_nettype wire

// ### test/tb.sv
// Self-checking bench of the main clock controller
`timescale 1ns/1ps
`default_nettype none
module tb
  import mcc_pkg::*;
;
  // Short counts keep the run brief; expectations use the same tables
  localparam int TBP [4] = '{16, 32, 80, 200};
  localparam int TNH [4] = '{0, 4, 8, 16};
  logic        clk, rst_n, psel, penable, pwrite, halt_cmd, halt_wake, ext_clr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, rnd, en_cnt;
  logic        pready, pslverr, core_clk_en, clock_out_pin, clock_out_oe, sl;
  logic        tone_pin, tone_oe, tick_irq, active_halt, full_halt, er, t_or, tick_q;
  logic [15:0] co_cnt, tn_edges, tn_half, m_co, m_edges, m_half;
  logic [1:0]  wsel, dv, c, pc;
  int          cyc = 0, r_last = 0, r_prev = 0, k, n_mismatch, compares;
  wire         wv = (wsel == 2'h0) ? tick_irq : (wsel == 2'h1) ? !active_halt : !full_halt;

  mcc_top #(.TB_PERIOD0(TBP[0]), .TB_PERIOD1(TBP[1]), .TB_PERIOD2(TBP[2]),
    .TB_PERIOD3(TBP[3]), .TONE_HALF1(TNH[1]), .TONE_HALF2(TNH[2]), .TONE_HALF3(TNH[3]))
  mcc_top_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_cmd(halt_cmd), .halt_wake(halt_wake), .core_clk_en(core_clk_en),
    .clock_out_pin(clock_out_pin), .clock_out_oe(clock_out_oe), .tone_pin(tone_pin),
    .tone_oe(tone_oe), .tick_irq(tick_irq), .active_halt(active_halt), .full_halt(full_halt));
  mcc_ext mcc_ext_i (.clk(clk), .clr(ext_clr), .co_pin(clock_out_pin), .tn_pin(tone_pin),
    .co_cnt(co_cnt), .tn_edges(tn_edges), .tn_half(tn_half));

  always #2 clk = ~clk;
  // Stamps of tick rises give period lengths without trusting the design
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    tick_q <= tick_irq;
    if (tick_irq && !tick_q)
    begin
      r_prev <= r_last;
      r_last <= cyc;
    end
  end

  // ==================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'h0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  function automatic logic [31:0] exp_en(input logic s, input logic [1:0] d, input int n);
    exp_en = s ? (n >> (d + 1)) : n;
  endfunction
  task automatic wrap_up;
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hang;
    chk(32'h0, 32'h1);
    wrap_up();
  endtask
  // Upper write data is noise: only the low byte is a register
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    rnd = lfsr(rnd);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {rnd[31:8], d};
    @(posedge clk);
    penable <= 1'h1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (pready === 1'h1) break;
    end
    if (i == 20) hang();
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wait_for(input logic [1:0] s, input int lim);
    int i;
    wsel = s;
    for (i = 0; i < lim; i++)
    begin
      @(posedge clk);
      if (wv === 1'h1) break;
    end
    if (i == lim) hang();
  endtask
  task automatic measure(input int n);
    int i;
    ext_clr <= 1'h1;
    @(posedge clk);
    ext_clr <= 1'h0;
    en_cnt = 32'h0;
    t_or = 1'h0;
    for (i = 0; i < n; i++)
    begin
      @(posedge clk);
      en_cnt = en_cnt + core_clk_en;
      t_or = t_or | tick_irq;
    end
    @(negedge clk);
    {m_co, m_edges, m_half} = {co_cnt, tn_edges, tn_half};
    @(posedge clk);
  endtask
  task automatic halt_pulse;
    halt_cmd <= 1'h1;
    @(posedge clk);
    halt_cmd <= 1'h0;
    @(posedge clk);
    @(posedge clk);
  endtask

  // ==================================================================
  // Main sequence
  initial
  begin
    {clk, rst_n, psel, penable, pwrite, halt_cmd, halt_wake, ext_clr} = '0;
    {paddr, pwdata, wsel} = '0;
    {n_mismatch, compares} = '0;
    rnd = 32'hBAAF3C0F;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    apb(1'h0, MCC_CSR_ADDR, 8'h00);
    chk(rd, {24'h0, MCC_CSR_RESET});
    apb(1'h0, MCC_TONE_ADDR, 8'h00);
    chk(rd, {24'h0, MCC_TONE_RESET});
    chk({core_clk_en, clock_out_oe, tone_oe, tick_irq}, 32'h8);
    apb(1'h0, 8'hB8, 8'h00);
    chk({rd[30:0], er}, 32'h1);
    $display("test reset done");
    for (k = 0; k < 8; k++)
    begin
      rnd = lfsr(rnd);
      dv = (k < 4) ? k[1:0] : rnd[1:0];
      sl = (k < 4) | rnd[2];
      apb(1'h1, MCC_CSR_ADDR, {1'h1, dv, sl, 4'h0});
      measure(64);
      measure(64);
      chk(en_cnt, exp_en(sl, dv, 64));
      chk({16'h0, m_co}, exp_en(sl, dv, 64));
      chk(clock_out_oe, 32'h1);
    end
    apb(1'h1, MCC_CSR_ADDR, 8'h00);
    measure(8);
    chk({m_co, 15'h0, clock_out_oe}, 32'h0);
    $display("test prescaler done");
    for (k = 1; k < 4; k++)
    begin
      apb(1'h1, MCC_TONE_ADDR, 8'h00);
      measure(2);
      chk({tone_pin, tone_oe}, 32'h0);
      apb(1'h1, MCC_TONE_ADDR, {6'h0, k[1:0]});
      measure(8 * TNH[k]);
      chk({16'h0, m_half}, TNH[k]);
      chk(tone_oe, 32'h1);
    end
    $display("test tone done");
    apb(1'h1, MCC_CSR_ADDR, 8'h02);
    // Enabling may raise the request off a period boundary; later rises fall on wraps
    repeat (4)
    begin
      wait_for(2'h0, 300);
      apb(1'h0, MCC_CSR_ADDR, 8'h00);
    end
    pc = 2'h0;
    for (k = 1; k <= 4; k++)
    begin
      c = k[1:0];
      apb(1'h1, MCC_CSR_ADDR, {4'h0, c, 2'h2});
      wait_for(2'h0, 1000);
      apb(1'h0, MCC_CSR_ADDR, 8'h00);
      chk(rd[0], 32'h1);
      chk(r_last - r_prev, TBP[pc]);
      apb(1'h0, MCC_CSR_ADDR, 8'h00);
      chk(rd[0], 32'h0);
      wait_for(2'h0, 1000);
      apb(1'h0, MCC_CSR_ADDR, 8'h00);
      chk(r_last - r_prev, TBP[c]);
      pc = c;
    end
    apb(1'h1, MCC_CSR_ADDR, 8'h00);
    apb(1'h0, MCC_CSR_ADDR, 8'h00);
    measure(40);
    chk(t_or, 32'h0);
    apb(1'h0, MCC_CSR_ADDR, 8'h00);
    chk(rd[0], 32'h1);
    $display("test time base done");
    apb(1'h1, MCC_TONE_ADDR, 8'h01);
    apb(1'h1, MCC_CSR_ADDR, 8'h82);
    wait_for(2'h0, 100);
    apb(1'h0, MCC_CSR_ADDR, 8'h00);
    halt_pulse();
    measure(5);
    chk({active_halt, full_halt}, 32'h2);
    chk(en_cnt, 32'h0);
    chk({16'h0, m_co}, 32'h0);
    chk(m_edges > 16'h0, 32'h1);
    wait_for(2'h1, 100);
    apb(1'h0, MCC_CSR_ADDR, 8'h00);
    apb(1'h1, MCC_CSR_ADDR, 8'h80);
    halt_pulse();
    chk({active_halt, full_halt}, 32'h1);
    measure(40);
    chk({m_edges, en_cnt[15:0]}, 32'h0);
    apb(1'h1, MCC_TONE_ADDR, 8'h00);
    halt_wake <= 1'h1;
    @(posedge clk);
    halt_wake <= 1'h0;
    wait_for(2'h2, 20);
    apb(1'h0, MCC_TONE_ADDR, 8'h00);
    chk(rd, 32'h1);
    $display("test halt done");
    rst_n <= 1'h0;
    @(posedge clk);
    rst_n <= 1'h1;
    apb(1'h0, MCC_CSR_ADDR, 8'h00);
    chk(rd, {24'h0, MCC_CSR_RESET});
    apb(1'h0, MCC_TONE_ADDR, 8'h00);
    chk(rd, {24'h0, MCC_TONE_RESET});
    chk({tone_oe, clock_out_oe, tick_irq}, 32'h0);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
